// ==== core/msout_top.sv ====
// Purpose: speed-reached, motion-complete outputs, gear settings, alarms
// Assumes: loop values and strobes are on CLK; pins are synchronised
// Notes: parameter port is word-indexed, 32-bit words
`timescale 1ns/1ps
`default_nettype none
`include "msout_params.svh"
module msout_top
#(
    parameter int TICK_CYC = `MSOUT_TICK_CYC
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // parameter port
    input wire msout_pkg::msout_wr_s WR,
    input wire logic [9:0] RD_IDX,
    output logic [31:0] RD_DATA,
    output logic WR_REFUSED,
    // drive state
    input wire logic SERVO_ON,
    input wire logic NET_MODE,
    input wire logic SPEED_MODE,
    input wire msout_pkg::msout_loop_s LOOP,
    input wire logic ENC_FAULT,
    input wire logic OVERSPEED,
    // triggers from pins and software
    input wire logic COMMAND_TRIGGER_IN,
    input wire logic EVENT_ONE_IN,
    input wire logic EVENT_TWO_IN,
    input wire logic SW_TRIGGER,
    input wire logic PROFILE_DONE,
    input wire logic [15:0] COMMAND_DONE_DELAY,
    input wire logic ALARM_CLEAR,
    // status outputs
    output logic SPEED_REACHED_OUT,
    output logic IN_POSITION_OUT,
    output logic COMMAND_DONE_OUT,
    output logic MOTION_COMPLETE_OUT,
    output logic PROFILE_START,
    output logic ENCODER_OVERRATE_ALARM,
    output logic POSITION_DEVIATION_ALARM
);
    import msout_pkg::*;

    // absolute value of a signed 32-bit difference
    function automatic logic [32:0] abs_diff(input logic signed [31:0] a,
                                            input logic signed [31:0] b);
        logic signed [32:0] d;
        d = 33'(a) - 33'(b);
        return d[32] ? 33'(-d) : 33'(d);
    endfunction

    // settings
    logic [31:0] gear_numerator_r;
    logic [31:0] gear_denominator_r;
    logic [31:0] encoder_output_count_r;
    logic [15:0] speed_window_r;
    logic [15:0] complete_select_r;
    logic [15:0] speed_dwell_time_r;
    logic [31:0] inpos_range_r;
    // pin synchronisers, first stage read only by the second
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic [2:0] pin_d_r;
    // timing
    logic [31:0] tick_cnt_r;
    logic tick_r;
    logic [15:0] dwell_cnt_r;
    logic [15:0] delay_cnt_r;
    msout_state_e state_r;
    msout_state_e state_nxt;
    // motion status
    logic cmd_done_r;
    logic inpos_r;
    logic complete_r;
    logic trig;
    logic in_win;
    logic mc_raw;
    logic [63:0] enc_rate;

    // synchronise the trigger pins before any logic sees them
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
            pin_d_r <= 3'h0;
        end
        else
        begin
            pin_s1_r <= {EVENT_TWO_IN, EVENT_ONE_IN, COMMAND_TRIGGER_IN};
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end

    // rising edge of any pin source, or the software trigger while high, starts a command
    assign trig = (|(pin_s2_r & ~pin_d_r)) | SW_TRIGGER; // [R9]

    // parameter writes; gear denominator locked while the servo runs, numerator only in network mode
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            gear_numerator_r <= `MSOUT_RST_GEAR_NUM; // [R1]
            gear_denominator_r <= `MSOUT_RST_GEAR_DEN; // [R2]
            encoder_output_count_r <= `MSOUT_RST_ENC_CNT; // [R4]
            speed_window_r <= `MSOUT_RST_SPD_WIN;
            complete_select_r <= `MSOUT_RST_CMP_SEL;
            speed_dwell_time_r <= `MSOUT_RST_SPD_DWELL;
            inpos_range_r <= `MSOUT_RST_INPOS_RNG; // [R16]
            WR_REFUSED <= 1'b0;
        end
        else
        begin
            WR_REFUSED <= 1'b0;
            if (WR.wr)
            begin
                case (WR.idx)
                    `MSOUT_OFS_GEAR_NUM:
                    begin
                        // lock only applies in network control mode
                        if (SERVO_ON && NET_MODE)
                            WR_REFUSED <= 1'b1; // [R1]
                        else
                            gear_numerator_r <= WR.data;
                    end
                    `MSOUT_OFS_GEAR_DEN:
                    begin
                        if (SERVO_ON)
                            WR_REFUSED <= 1'b1; // [R2]
                        else
                            gear_denominator_r <= WR.data;
                    end
                    `MSOUT_OFS_ENC_CNT: encoder_output_count_r <= WR.data;
                    `MSOUT_OFS_SPD_WIN: speed_window_r <= WR.data[15:0];
                    `MSOUT_OFS_CMP_SEL: complete_select_r <= WR.data[15:0];
                    `MSOUT_OFS_SPD_DWELL: speed_dwell_time_r <= WR.data[15:0];
                    `MSOUT_OFS_INPOS_RNG: inpos_range_r <= WR.data;
                    default: WR_REFUSED <= 1'b1;
                endcase
            end
        end
    end

    // readback of settings; unmapped reads return zero
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            RD_DATA <= 32'h0000_0000;
        else
        begin
            case (RD_IDX)
                `MSOUT_OFS_GEAR_NUM: RD_DATA <= gear_numerator_r;
                `MSOUT_OFS_GEAR_DEN: RD_DATA <= gear_denominator_r;
                `MSOUT_OFS_ENC_CNT: RD_DATA <= encoder_output_count_r;
                `MSOUT_OFS_SPD_WIN: RD_DATA <= {16'h0000, speed_window_r};
                `MSOUT_OFS_CMP_SEL: RD_DATA <= {16'h0000, complete_select_r};
                `MSOUT_OFS_SPD_DWELL: RD_DATA <= {16'h0000, speed_dwell_time_r};
                `MSOUT_OFS_INPOS_RNG: RD_DATA <= inpos_range_r;
                default: RD_DATA <= 32'h0000_0000;
            endcase
        end
    end

    // millisecond tick from the system clock
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end
        else if (tick_cnt_r >= 32'(TICK_CYC - 1))
        begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b1; // [R17]
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
            tick_r <= 1'b0;
        end
    end

    // unramped command against filtered feedback; zero window never matches
    assign in_win = abs_diff(LOOP.spd_cmd, LOOP.spd_fb) <
        {17'h0_0000, speed_window_r}; // [R6] [R7]

    // dwell count restarts on leaving the window
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            dwell_cnt_r <= 16'h0000;
        else if (!in_win)
            dwell_cnt_r <= 16'h0000; // [R8]
        else if (tick_r && dwell_cnt_r != 16'hffff)
            dwell_cnt_r <= dwell_cnt_r + 16'h0001; // [R17]
    end

    // speed reached output; dwell time is only required in speed mode
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            SPEED_REACHED_OUT <= 1'b0;
        else
            SPEED_REACHED_OUT <= in_win &&
                (!SPEED_MODE || dwell_cnt_r >= speed_dwell_time_r); // [R6] [R8]
    end

    // command sequencer: next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            MSOUT_IDLE: state_nxt = state_r;
            MSOUT_RUN:
                if (PROFILE_DONE)
                    state_nxt = (COMMAND_DONE_DELAY == 16'h0000) ? MSOUT_DONE : MSOUT_DELAY;
            MSOUT_DELAY:
                if (tick_r && delay_cnt_r + 16'h0001 >= COMMAND_DONE_DELAY)
                    state_nxt = MSOUT_DONE; // [R10]
            MSOUT_DONE: state_nxt = state_r;
            default: state_nxt = MSOUT_IDLE;
        endcase
        if (trig)
            state_nxt = MSOUT_RUN; // [R9]
    end

    // sequencer state and delay counter
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            state_r <= MSOUT_IDLE;
            delay_cnt_r <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r != MSOUT_DELAY || trig)
                delay_cnt_r <= 16'h0000;
            else if (tick_r)
                delay_cnt_r <= delay_cnt_r + 16'h0001;
        end
    end

    // profile start pulse, command-done and in-position
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            PROFILE_START <= 1'b0;
            cmd_done_r <= 1'b0;
            inpos_r <= 1'b0;
        end
        else
        begin
            PROFILE_START <= trig; // [R9]
            cmd_done_r <= !trig && state_nxt == MSOUT_DONE; // [R10]
            // error magnitude must be strictly under the range
            inpos_r <= !trig &&
                abs_diff(LOOP.pos_err, 32'sh0000_0000) < {1'b0, inpos_range_r}; // [R11] [R16]
        end
    end

    assign mc_raw = cmd_done_r && inpos_r; // [R12]

    // motion complete, latching variant holds until next trigger
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            complete_r <= 1'b0;
        else if (trig)
            complete_r <= 1'b0; // [R9]
        else if (mc_raw)
            complete_r <= 1'b1; // [R14]
    end

    // one variant drives the output, chosen by digit X
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            MOTION_COMPLETE_OUT <= 1'b0;
            IN_POSITION_OUT <= 1'b0;
            COMMAND_DONE_OUT <= 1'b0;
        end
        else
        begin
            MOTION_COMPLETE_OUT <= !trig && (complete_select_r[`MSOUT_SEL_X_BIT] ?
                (complete_r || mc_raw) : mc_raw); // [R12] [R13]
            IN_POSITION_OUT <= inpos_r;
            COMMAND_DONE_OUT <= cmd_done_r;
        end
    end

    // output pulse rate: rpm/60 * count * 4, compared without division
    assign enc_rate = 64'(LOOP.motor_rpm) * 64'(encoder_output_count_r) * `MSOUT_ENC_SCALE;

    // alarms latch until cleared; a new cause wins over the clear
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            ENCODER_OVERRATE_ALARM <= 1'b0;
            POSITION_DEVIATION_ALARM <= 1'b0;
        end
        else
        begin
            if (enc_rate > `MSOUT_ENC_LIMIT_HZ * `MSOUT_SEC_PER_MIN || ENC_FAULT || OVERSPEED)
                ENCODER_OVERRATE_ALARM <= 1'b1; // [R5]
            else if (ALARM_CLEAR)
                ENCODER_OVERRATE_ALARM <= 1'b0; // [R18]
            if (complete_select_r[`MSOUT_SEL_Y_BIT] && complete_r && !inpos_r && !trig)
                POSITION_DEVIATION_ALARM <= 1'b1; // [R15]
            else if (ALARM_CLEAR)
                POSITION_DEVIATION_ALARM <= 1'b0; // [R18]
        end
    end

    // refused gear writes while servo on, numerator only in network mode
    gear_lock_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R2]
        WR.wr && WR.idx == `MSOUT_OFS_GEAR_DEN && SERVO_ON |=> WR_REFUSED &&
        $stable(gear_denominator_r))
        else $error("denominator changed while servo on");
    num_lock_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R1]
        WR.wr && WR.idx == `MSOUT_OFS_GEAR_NUM && SERVO_ON && NET_MODE |=>
        $stable(gear_numerator_r))
        else $error("numerator changed while servo on");
    // zero window keeps speed reached off
    spd_zero_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R6]
        speed_window_r == 16'h0000 |=> !SPEED_REACHED_OUT)
        else $error("speed reached with zero window");
    // leaving window drops output next cycle
    spd_leave_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R8]
        !in_win |=> !SPEED_REACHED_OUT && dwell_cnt_r == 16'h0000)
        else $error("speed reached outside window");
    // trigger clears all completion status
    sequence trig_s;
        trig;
    endsequence
    trig_clear_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R9]
        trig_s |=> PROFILE_START && !cmd_done_r && !inpos_r && !complete_r ##1
        !MOTION_COMPLETE_OUT)
        else $error("trigger did not clear status");
    // non-latching mode follows done and inpos
    mc_plain_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R12]
        !complete_select_r[`MSOUT_SEL_X_BIT] && !trig |=> MOTION_COMPLETE_OUT == $past(mc_raw))
        else $error("plain complete mismatch");
    // latching mode holds without trigger
    mc_hold_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R14]
        complete_r && !trig |=> complete_r)
        else $error("latched complete dropped");
    // deviation alarm sticks until clear
    dev_alarm_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R18]
        POSITION_DEVIATION_ALARM && !ALARM_CLEAR |=> POSITION_DEVIATION_ALARM)
        else $error("deviation alarm dropped");
    // no deviation alarm raised when digit Y is zero
    dev_off_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R15]
        !complete_select_r[`MSOUT_SEL_Y_BIT] && !POSITION_DEVIATION_ALARM |=>
        !POSITION_DEVIATION_ALARM)
        else $error("deviation alarm while disabled");
endmodule // msout_top
`default_nettype wire

// ==== core/msout_params.svh ====
// Purpose: constants for the motion status output block
// Assumes: 40 MHz system clock, parameter port addressed by word index
// Notes: offsets are word indices of the parameter space
// Functional notes
// R1 - numerator 32-bit default 128, writable servo-off
// R2 - denominator 32-bit default 10, locked servo-on
// R3 - host keeps ratio between 1/50, 25600
// R4 - encoder pulse count 32-bit default 2500
// R5 - over-rate alarm when speed*count*4 exceeds 19.8MHz
// R6 - speed reached when error below window
// R7 - compare unramped user speed command
// R8 - speed mode dwell ms before reached
// R9 - trigger starts profile, clears done flags
// R10 - command done after profile plus delay
// R11 - in-position while error within range
// R12 - non-latching complete equals done and inpos
// R13 - select digit X picks latching variant
// R14 - latched complete holds until next trigger
// R15 - digit Y enables position deviation alarm
// R16 - in-position range 32-bit default 12800
// R17 - timers use millisecond tick, synchronous
// R18 - alarms latch until explicit clear
`ifndef MSOUT_PARAMS_SVH
`define MSOUT_PARAMS_SVH
`define MSOUT_OFS_GEAR_NUM 10'h158
`define MSOUT_OFS_GEAR_DEN 10'h15a
`define MSOUT_OFS_ENC_CNT 10'h15c
`define MSOUT_OFS_SPD_WIN 10'h15e
`define MSOUT_OFS_CMP_SEL 10'h160
`define MSOUT_OFS_SPD_DWELL 10'h162
`define MSOUT_OFS_INPOS_RNG 10'h16c
`define MSOUT_RST_GEAR_NUM 32'h0000_0080
`define MSOUT_RST_GEAR_DEN 32'h0000_000a
`define MSOUT_RST_ENC_CNT 32'h0000_09c4
`define MSOUT_RST_SPD_WIN 16'h000a
`define MSOUT_RST_CMP_SEL 16'h0000
`define MSOUT_RST_SPD_DWELL 16'h0000
`define MSOUT_RST_INPOS_RNG 32'h0000_3200
`define MSOUT_SEL_X_BIT 0
`define MSOUT_SEL_Y_BIT 4
`define MSOUT_CLK_KHZ 40000
`define MSOUT_TICK_MS 1
`define MSOUT_TICK_CYC (`MSOUT_CLK_KHZ * `MSOUT_TICK_MS)
`define MSOUT_ENC_LIMIT_HZ 64'h0000_0000_012e_1fc0
`define MSOUT_ENC_SCALE 64'h0000_0000_0000_0004
`define MSOUT_SEC_PER_MIN 64'h0000_0000_0000_003c
`endif

// ==== core/msout_pkg.sv ====
// Purpose: types shared by the motion status output block
// Assumes: msout_params.svh supplies numbers
// Notes: none
package msout_pkg;
    // one parameter write from the host
    typedef struct packed {
        logic        wr;
        logic [9:0]  idx;
        logic [31:0] data;
    } msout_wr_s;
    // feedback from drive loops
    typedef struct packed {
        logic signed [31:0] spd_cmd;
        logic signed [31:0] spd_fb;
        logic signed [31:0] pos_err;
        logic [31:0] motor_rpm;
    } msout_loop_s;
    // motion sequencer states, gray along idle-run-delay-done
    typedef enum logic [1:0] {
        MSOUT_IDLE = 2'b00,
        MSOUT_RUN = 2'b01,
        MSOUT_DELAY = 2'b11,
        MSOUT_DONE = 2'b10
    } msout_state_e;
endpackage

// ==== tb/msout_host_model.sv ====
// Purpose: host controller model driving the parameter port
// Assumes: drives just after the falling edge, one 32-bit word per write
// Notes: gear writes that would give a bad ratio are never sent
`timescale 1ns/1ps
`default_nettype none
module msout_host_model
(
    // clock
    input wire logic CLK,
    // parameter port
    output var msout_pkg::msout_wr_s WR,
    output logic [9:0] RD_IDX,
    input wire logic [31:0] RD_DATA,
    input wire logic WR_REFUSED
);
    import msout_pkg::*;
    logic [31:0] num_r = 32'h0000_0080; // host copy of the numerator
    logic [31:0] den_r = 32'h0000_000a; // host copy of the denominator
    logic refused_seen = 1'b0; // refusal seen for the last write
    initial
    begin
        WR = '0;
        RD_IDX = '0;
    end
    // ratio must stay strictly inside the open interval, else the motor may lurch
    function automatic logic ratio_ok(input logic [31:0] n, input logic [31:0] d);
        return (64'(n) * 64'd50 > 64'(d)) && (64'(n) < 64'(d) * 64'd25600);
    endfunction
    // one write: strobe up for one edge, data scrambled once released
    task automatic put(input logic [9:0] idx, input logic [31:0] data);
        logic [31:0] n;
        logic [31:0] d;
        n = (idx == 10'h158) ? data : num_r;
        d = (idx == 10'h15a) ? data : den_r;
        if (!ratio_ok(n, d))
        begin
            $display("host skips gear write with bad ratio");
            return;
        end
        @(negedge CLK);
        WR = {1'b1, idx, data};
        @(negedge CLK);
        WR = {1'b0, ~idx, ~data};
        refused_seen = WR_REFUSED;
        if (!WR_REFUSED && idx == 10'h158)
            num_r = data;
        if (!WR_REFUSED && idx == 10'h15a)
            den_r = data;
    endtask
    // one read: readback lands one cycle after the index
    task automatic get(input logic [9:0] idx, output logic [31:0] data);
        @(negedge CLK);
        RD_IDX = idx;
        @(negedge CLK);
        data = RD_DATA;
    endtask
endmodule // msout_host_model
`default_nettype wire

// ==== tb/msout_top_tb_top.sv ====
// Purpose: self-checking bench for the motion status block
// Assumes: tick shortened to 4 cycles, inputs driven on falling edges
// Notes: every wait is bounded; a timeout counts as a mismatch
`timescale 1ns/1ps
`default_nettype none
module msout_top_tb_top;
    import msout_pkg::*;
    localparam int SR = 6, IP = 5, CD = 4, MC = 3, PS = 2, EA = 1, DA = 0; // st bits
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    msout_wr_s wr;
    logic [9:0] rd_idx;
    logic [31:0] rd_data;
    logic refused;
    logic servo_on = 1'b0, net_mode = 1'b1, speed_mode = 1'b0;
    msout_loop_s loop = '0;
    logic enc_fault = 1'b0, overspeed = 1'b0, alarm_clear = 1'b0, prof_done = 1'b0;
    logic [3:0] trig = '0; // software, pin, event one, event two
    logic [15:0] done_delay = 16'h0000;
    logic [6:0] st; // status outputs gathered for bounded waits
    logic [31:0] rv;
    int fbv[4] = '{96, 95, 105, 104}; // feedback around a window of 5
    logic fbe[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    int miscompares = 0;
    int samples_checked = 0;
    // clock at 40 MHz
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    msout_host_model host (.CLK(clk), .WR(wr), .RD_IDX(rd_idx), .RD_DATA(rd_data),
        .WR_REFUSED(refused));
    msout_top #(.TICK_CYC(4)) i_dut (.CLK(clk), .RST_N(rst_n), .WR(wr), .RD_IDX(rd_idx),
        .RD_DATA(rd_data), .WR_REFUSED(refused), .SERVO_ON(servo_on), .NET_MODE(net_mode),
        .SPEED_MODE(speed_mode), .LOOP(loop), .ENC_FAULT(enc_fault), .OVERSPEED(overspeed),
        .COMMAND_TRIGGER_IN(trig[1]), .EVENT_ONE_IN(trig[2]), .EVENT_TWO_IN(trig[3]),
        .SW_TRIGGER(trig[0]), .PROFILE_DONE(prof_done), .COMMAND_DONE_DELAY(done_delay),
        .ALARM_CLEAR(alarm_clear), .SPEED_REACHED_OUT(st[SR]), .IN_POSITION_OUT(st[IP]),
        .COMMAND_DONE_OUT(st[CD]), .MOTION_COMPLETE_OUT(st[MC]), .PROFILE_START(st[PS]),
        .ENCODER_OVERRATE_ALARM(st[EA]), .POSITION_DEVIATION_ALARM(st[DA]));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait for one status bit, then compare it
    task automatic wait_st(input int b, input logic v, input int lim, input string what);
        for (int k = 0; k < lim && st[b] !== v; k++)
            @(negedge clk);
        chk(what, {31'h0, st[b]}, {31'h0, v});
        if (st[b] !== v)
            give_verdict();
    endtask
    task automatic stb(input int b, input logic v, input string what);
        chk(what, {31'h0, st[b]}, {31'h0, v});
    endtask
    task automatic wrw(input logic [9:0] idx, input logic [31:0] d, input logic exp_ref);
        host.put(idx, d);
        chk("write refusal", {31'h0, host.refused_seen}, {31'h0, exp_ref});
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        host.get(idx, rv);
        chk("readback", rv, exp);
    endtask
    // one-cycle trigger; pins go through the synchroniser, so allow slack
    task automatic fire(input int src);
        trig[src] = 1'b1;
        wt(1);
        trig[src] = 1'b0;
        wait_st(PS, 1'b1, 6, "profile start");
    endtask
    task automatic pulse_done();
        prof_done = 1'b1;
        wt(1);
        prof_done = 1'b0;
    endtask
    task automatic clr();
        alarm_clear = 1'b1;
        wt(1);
        alarm_clear = 1'b0;
        wt(1);
    endtask
    initial
    begin
        wt(2);
        rst_n = 1'b1;
        rdc(10'h158, 32'h0000_0080);
        rdc(10'h15a, 32'h0000_000a);
        rdc(10'h15c, 32'h0000_09c4);
        rdc(10'h15e, 32'h0000_000a);
        rdc(10'h160, 32'h0000_0000);
        rdc(10'h162, 32'h0000_0000);
        rdc(10'h16c, 32'h0000_3200);
        $display("test defaults done");
        servo_on = 1'b1;
        wrw(10'h158, 32'h0000_0100, 1'b1);
        wrw(10'h15a, 32'h0000_0014, 1'b1);
        wrw(10'h150, 32'h0000_0001, 1'b1);
        rdc(10'h158, 32'h0000_0080);
        net_mode = 1'b0;
        wrw(10'h158, 32'h0000_0100, 1'b0);
        wrw(10'h15a, 32'h0000_0014, 1'b1);
        servo_on = 1'b0;
        wrw(10'h15a, 32'h0000_0014, 1'b0);
        rdc(10'h158, 32'h0000_0100);
        rdc(10'h15a, 32'h0000_0014);
        wrw(10'h15c, 32'hffff_ffff, 1'b0);
        rdc(10'h15c, 32'hffff_ffff);
        wrw(10'h15c, 32'h0000_09c4, 1'b0);
        wrw(10'h16c, 32'h0000_0100, 1'b0);
        rdc(10'h16c, 32'h0000_0100);
        wrw(10'h16c, 32'h0000_3200, 1'b0);
        $display("test gear locks done");
        wrw(10'h15e, 32'h0001_0005, 1'b0);
        rdc(10'h15e, 32'h0000_0005);
        loop.spd_cmd = 32'sd100;
        foreach (fbv[i])
        begin
            loop.spd_fb = 32'(fbv[i]);
            wt(2);
            stb(SR, fbe[i], "speed reached");
        end
        wrw(10'h15e, 32'h0000_0000, 1'b0);
        loop.spd_fb = 32'sd100;
        wt(3);
        stb(SR, 1'b0, "zero window");
        wrw(10'h15e, 32'h0000_0005, 1'b0);
        wrw(10'h162, 32'h0000_0002, 1'b0);
        speed_mode = 1'b1;
        for (int r = 0; r < 2; r++)
        begin
            loop.spd_fb = 32'sd0;
            wt(3);
            stb(SR, 1'b0, "out of window");
            loop.spd_fb = 32'sd100;
            wt(3);
            stb(SR, 1'b0, "dwell running");
            wait_st(SR, 1'b1, 20, "dwell over");
        end
        $display("test speed reached done");
        loop.pos_err = 32'sd12799;
        fire(0);
        pulse_done();
        wait_st(MC, 1'b1, 6, "complete");
        stb(IP, 1'b1, "in position");
        stb(CD, 1'b1, "command done");
        loop.pos_err = 32'sd12800;
        wait_st(MC, 1'b0, 4, "complete drops");
        stb(IP, 1'b0, "range edge");
        wt(3);
        stb(DA, 1'b0, "deviation off");
        loop.pos_err = 32'sd12799;
        wait_st(MC, 1'b1, 4, "complete again");
        fire(3);
        wait_st(MC, 1'b0, 4, "trigger clears");
        wait_st(CD, 1'b0, 4, "done cleared");
        wrw(10'h160, 32'h0000_0011, 1'b0);
        done_delay = 16'h0002;
        fire(1);
        pulse_done();
        wt(4);
        stb(CD, 1'b0, "done delayed");
        wait_st(CD, 1'b1, 20, "done after delay");
        wait_st(MC, 1'b1, 4, "latched complete");
        loop.pos_err = 32'sd20000;
        wait_st(DA, 1'b1, 6, "deviation alarm");
        stb(MC, 1'b1, "complete held");
        fire(2);
        wait_st(MC, 1'b0, 4, "latch cleared");
        stb(DA, 1'b1, "alarm held");
        clr();
        stb(DA, 1'b0, "alarm cleared");
        $display("test motion complete done");
        loop.motor_rpm = 32'd118800;
        wt(3);
        stb(EA, 1'b0, "rate at limit");
        for (int c = 0; c < 3; c++)
        begin
            loop.motor_rpm = (c == 0) ? 32'd118801 : 32'd0;
            enc_fault = (c == 1);
            overspeed = (c == 2);
            wait_st(EA, 1'b1, 6, "over-rate raised");
            loop.motor_rpm = 32'd0;
            enc_fault = 1'b0;
            overspeed = 1'b0;
            wt(2);
            stb(EA, 1'b1, "over-rate held");
            clr();
            stb(EA, 1'b0, "over-rate cleared");
        end
        $display("test over-rate done");
        give_verdict();
    end
endmodule // msout_top_tb_top
`default_nettype wire
